// *** logic/pbio_defs.vh ***
// Constants for the bridge I/O window and link-side error status block
`ifndef PBIO_DEFS_VH
`define PBIO_DEFS_VH

// Configuration byte offsets
`define PBIO_OFF_LAT_TMR     8'h1B
`define PBIO_OFF_IO_BASE     8'h1C
`define PBIO_OFF_IO_LIMIT    8'h1D
`define PBIO_OFF_STS_LO      8'h1E
`define PBIO_OFF_STS_HI      8'h1F

// Reset and hardwired values
`define PBIO_LAT_TMR_VAL     8'h00
`define PBIO_NIB_RESET       4'h0
`define PBIO_STS_RSVD        4'h0
`define PBIO_IO_CAP_16       4'h0
`define PBIO_BYTE_ZERO       8'h00

// Error flag positions within the status high byte (status bits 15..12)
`define PBIO_BIT_DPE         3'h7
`define PBIO_BIT_SYSERR      3'h6
`define PBIO_BIT_RMA         3'h5
`define PBIO_BIT_RTA         3'h4

// Programmable nibble of the window bound bytes
`define PBIO_NIB_MSB         7
`define PBIO_NIB_LSB         4

// Window decode fill for the low twelve address bits
`define PBIO_LOW_BASE_FILL   12'h000
`define PBIO_LOW_LIMIT_FILL  12'hFFF

`endif

// *** logic/pbio_window_dec.v ***
// Registered I/O window compare for one 16-bit I/O address
`timescale 1ns/1ns
`default_nettype none
`include "pbio_defs.vh"

module pbio_window_dec (
   // Clock and reset
   input  wire        clk_sys,
   input  wire        rst_n,
   // Window bounds
   input  wire [3:0]  base_nib,
   input  wire [3:0]  limit_nib,
   // Address to check
   input  wire        io_valid,
   input  wire [15:0] io_addr,
   // Result
   output reg         fwd_valid_r,
   output reg         fwd_hit_r
);

   wire [15:0] lo_bound;
   wire [15:0] hi_bound;
   wire        in_win;

   assign lo_bound = {base_nib, `PBIO_LOW_BASE_FILL};
   assign hi_bound = {limit_nib, `PBIO_LOW_LIMIT_FILL};
   assign in_win   = (io_addr >= lo_bound) && (io_addr <= hi_bound);

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         fwd_valid_r <= 1'b0;
         fwd_hit_r   <= 1'b0;
      end else begin
         fwd_valid_r <= io_valid;
         fwd_hit_r   <= io_valid & in_win;
      end
   end

endmodule // pbio_window_dec

`default_nettype wire

// *** logic/pbio_err_flag.v ***
// One write-one-to-clear sticky error flag with set priority
`timescale 1ns/1ns
`default_nettype none

module pbio_err_flag (
   // Clock and reset
   input  wire clk_sys,
   input  wire rst_n,
   // Event and software clear
   input  wire set_ev,
   input  wire clr_w1,
   // Flag
   output reg  flag_r
);

   always @(posedge clk_sys) begin
      if (!rst_n)
         flag_r <= 1'b0;
      else if (set_ev)
         flag_r <= 1'b1;
      else if (clr_w1)
         flag_r <= 1'b0;
   end

endmodule // pbio_err_flag

`default_nettype wire

// *** logic/pbio_bridge.v ***
// Bridge configuration block: I/O window registers and link-side error status
// Operation
// - The secondary latency timer at 1Bh is read-only and always reads zero.
// - I/O base bits 7:4 are writable, hold A[15:12] of the window bottom and reset to zero.
// - I/O base bits 3:0 read as zero, advertising 16-bit I/O decode only.
// - I/O limit bits 7:4 are writable, hold A[15:12] of the window top and reset to zero.
// - I/O limit bits 3:0 read as zero, advertising 16-bit I/O decode only.
// - An I/O access is forwarded when base <= A[15:12] <= limit.
// - For decode the base's low twelve address bits are taken as zeros.
// - For decode the limit's low twelve address bits are taken as ones.
// - The 16-bit link-side status holds error flags that reset to zero.
// - Bit 15 sets on any poisoned TLP from the link, regardless of parity response enable.
// - Bit 14 sets on a fatal or nonfatal error message, not gated by system error enable.
// - Bit 13 sets on a completion with Unsupported Request status.
// - Bit 12 sets on a completion with Completer Abort status.
`timescale 1ns/1ns
`default_nettype none
`include "pbio_defs.vh"

module pbio_bridge (
   // Clock and reset
   input  wire        clk_sys,
   input  wire        rst_n,
   // Configuration byte access, this device and function already selected
   input  wire        cfg_wr,
   input  wire        cfg_rd,
   input  wire [7:0]  cfg_addr,
   input  wire [7:0]  cfg_wdata,
   output reg  [7:0]  cfg_rdata_r,
   output reg         cfg_rvalid_r,
   // Link-side events, one-cycle pulses from the link logic
   input  wire        ev_poisoned_tlp,
   input  wire        ev_err_msg,
   input  wire        ev_cpl_ur,
   input  wire        ev_cpl_ca,
   // I/O forwarding decode
   input  wire        io_valid,
   input  wire [15:0] io_addr,
   output wire        io_fwd_valid_r,
   output wire        io_fwd_hit_r
);

   // Register map, one byte per offset
   //   Offsets are byte addresses within this function's configuration space.
   //   1Bh  latency timer: reads 00h, writes dropped
   //   1Ch  window base: 7:4 hold A[15:12] of the bottom, 3:0 read 0h (16-bit decode)
   //   1Dh  window limit: 7:4 hold A[15:12] of the top, 3:0 read 0h (16-bit decode)
   //   1Eh  status low byte: reads 00h, writes dropped
   //   1Fh  status high byte, write one to clear, a same-cycle event wins:
   //          bit 7  poisoned TLP received
   //          bit 6  fatal or nonfatal error message received
   //          bit 5  completion with Unsupported Request status
   //          bit 4  completion with Completer Abort status
   //          3:0    read zero
   //   Other offsets read 00h and ignore writes.
   //
   // Window decode, applied to every address offered on the I/O decode port:
   //   bottom = {base nibble, 000h}, top = {limit nibble, FFFh}
   //   forwarded when bottom <= address <= top; answer one cycle later, for one cycle.
   //
   // A base above the limit closes the window; that is the only way to switch it off.
   // After reset both bounds are zero, so 0000h to 0FFFh is still forwarded.
   //
   // A read returns its byte one cycle after the strobe, for one cycle. A write takes
   // effect at its own edge; a read in the same cycle still returns the old byte.
   //
   // Event inputs are one-cycle pulses; a held input sets its flag on every cycle,
   // so a clear only sticks once the input has dropped.
   //
   // Not here: the lower status bits, the memory windows, bridge control and the
   // primary-side registers live in other blocks.

   // Window bounds: only the upper nibble of each byte is storage
   reg  [3:0] io_window_base_r;
   reg  [3:0] io_window_base_nxt;
   reg  [3:0] io_window_limit_r;
   reg  [3:0] io_window_limit_nxt;

   // Write strobes of the writable bytes
   wire       wr_base;
   wire       wr_limit;
   wire       wr_sts_hi;

   // Link-side events as they reach the flags
   wire       set_dpe;
   wire       set_syserr;
   wire       set_rma;
   wire       set_rta;

   // Software clears, one per flag
   wire       clr_dpe;
   wire       clr_syserr;
   wire       clr_rma;
   wire       clr_rta;

   // Sticky flags
   wire       dpe_flag;
   wire       syserr_flag;
   wire       rma_flag;
   wire       rta_flag;

   // Read image of every mapped byte
   wire [7:0] lat_tmr_img;
   wire [7:0] base_img;
   wire [7:0] limit_img;
   wire [7:0] sts_lo_img;
   wire [7:0] sts_hi_img;

   // Read byte select
   reg  [7:0] rd_img;

   // Next values of the read outputs
   reg  [7:0] cfg_rdata_nxt;
   reg        cfg_rvalid_nxt;

   // Byte offset match, used by the write decodes; the read select uses a case
   function is_off;
      input [7:0] a;
      input [7:0] off;
      begin
         is_off = (a == off);
      end
   endfunction

   // Programmable nibble of a written bound byte
   function [3:0] hi_nib;
      input [7:0] d;
      begin
         hi_nib = d[`PBIO_NIB_MSB:`PBIO_NIB_LSB];
      end
   endfunction

   // Read image of a bound byte: stored nibble over the fixed 16-bit capability code
   function [7:0] bound_img;
      input [3:0] nib;
      begin
         bound_img = {nib, `PBIO_IO_CAP_16};
      end
   endfunction

   // Write-one-to-clear request for one flag of the status high byte
   function w1c_req;
      input       wr;
      input [7:0] d;
      input [2:0] pos;
      begin
         w1c_req = wr & d[pos];
      end
   endfunction

   // Writes to 1Bh, 1Eh and the capability nibbles decode nowhere, so they leave no trace
   assign wr_base   = cfg_wr & is_off(cfg_addr, `PBIO_OFF_IO_BASE);
   assign wr_limit  = cfg_wr & is_off(cfg_addr, `PBIO_OFF_IO_LIMIT);
   assign wr_sts_hi = cfg_wr & is_off(cfg_addr, `PBIO_OFF_STS_HI);

   // Bound next values hold unless their own byte is written
   always @* begin
      io_window_base_nxt = io_window_base_r;
      if (wr_base) begin
         io_window_base_nxt = hi_nib(cfg_wdata);
      end
   end

   always @* begin
      io_window_limit_nxt = io_window_limit_r;
      if (wr_limit) begin
         io_window_limit_nxt = hi_nib(cfg_wdata);
      end
   end

   // Bound storage
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         io_window_base_r <= `PBIO_NIB_RESET;
      end else begin
         io_window_base_r <= io_window_base_nxt;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         io_window_limit_r <= `PBIO_NIB_RESET;
      end else begin
         io_window_limit_r <= io_window_limit_nxt;
      end
   end

   // Events are synchronous pulses from core-clock link logic, so no synchroniser
   assign set_dpe    = ev_poisoned_tlp;
   assign set_syserr = ev_err_msg;
   assign set_rma    = ev_cpl_ur;
   assign set_rta    = ev_cpl_ca;

   // A set in the same cycle wins inside the flag, so a clear never hides a new event
   assign clr_dpe    = w1c_req(wr_sts_hi, cfg_wdata, `PBIO_BIT_DPE);
   assign clr_syserr = w1c_req(wr_sts_hi, cfg_wdata, `PBIO_BIT_SYSERR);
   assign clr_rma    = w1c_req(wr_sts_hi, cfg_wdata, `PBIO_BIT_RMA);
   assign clr_rta    = w1c_req(wr_sts_hi, cfg_wdata, `PBIO_BIT_RTA);

   // Status bit 15: poisoned TLP, not gated by parity response enable
   pbio_err_flag u_dpe (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .set_ev  (set_dpe),
      .clr_w1  (clr_dpe),
      .flag_r  (dpe_flag)
   );

   // Status bit 14: error message, not gated by system error enable
   pbio_err_flag u_syserr (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .set_ev  (set_syserr),
      .clr_w1  (clr_syserr),
      .flag_r  (syserr_flag)
   );

   // Status bit 13: completion with Unsupported Request status
   pbio_err_flag u_rma (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .set_ev  (set_rma),
      .clr_w1  (clr_rma),
      .flag_r  (rma_flag)
   );

   // Status bit 12: completion with Completer Abort status
   pbio_err_flag u_rta (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .set_ev  (set_rta),
      .clr_w1  (clr_rta),
      .flag_r  (rta_flag)
   );

   // Read images; the fixed parts never depend on what was written
   assign lat_tmr_img = `PBIO_LAT_TMR_VAL;
   assign base_img    = bound_img(io_window_base_r);
   assign limit_img   = bound_img(io_window_limit_r);
   assign sts_lo_img  = `PBIO_BYTE_ZERO;
   assign sts_hi_img  = {dpe_flag, syserr_flag, rma_flag, rta_flag, `PBIO_STS_RSVD};

   // Byte select for reads; unmapped offsets read zero
   always @* begin
      rd_img = `PBIO_BYTE_ZERO;
      case (cfg_addr)
         `PBIO_OFF_LAT_TMR: begin
            rd_img = lat_tmr_img;
         end
         `PBIO_OFF_IO_BASE: begin
            rd_img = base_img;
         end
         `PBIO_OFF_IO_LIMIT: begin
            rd_img = limit_img;
         end
         `PBIO_OFF_STS_LO: begin
            rd_img = sts_lo_img;
         end
         `PBIO_OFF_STS_HI: begin
            rd_img = sts_hi_img;
         end
         default: begin
            rd_img = `PBIO_BYTE_ZERO;
         end
      endcase
   end

   // Data reads zero outside a read, so a stale byte never rides on an idle cycle
   always @* begin
      cfg_rvalid_nxt = cfg_rd;
      cfg_rdata_nxt  = `PBIO_BYTE_ZERO;
      if (cfg_rd) begin
         cfg_rdata_nxt = rd_img;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         cfg_rdata_r  <= `PBIO_BYTE_ZERO;
         cfg_rvalid_r <= 1'b0;
      end else begin
         cfg_rdata_r  <= cfg_rdata_nxt;
         cfg_rvalid_r <= cfg_rvalid_nxt;
      end
   end

   // The compare sees the bounds as stored, so a new bound applies from the next cycle
   pbio_window_dec u_win (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .base_nib    (io_window_base_r),
      .limit_nib   (io_window_limit_r),
      .io_valid    (io_valid),
      .io_addr     (io_addr),
      .fwd_valid_r (io_fwd_valid_r),
      .fwd_hit_r   (io_fwd_hit_r)
   );

endmodule // pbio_bridge

`default_nettype wire

// *** sim/pbio_link_model.sv ***
// Link partner model: raises one error event pulse per request
`timescale 1ns/1ns
`default_nettype none
module pbio_link_model (
   // Clock
   input  wire logic       clk_sys,
   // Request: fire one event of the given kind
   input  wire logic       fire,
   input  wire logic [1:0] kind,
   // Events: bit 3 poisoned, 2 error message, 1 UR, 0 CA
   output var  logic [3:0] ev_r
);
   // One cycle only, as the link logic delivers events as pulses
   always @(posedge clk_sys) begin
      ev_r <= fire ? (4'h1 << kind) : 4'h0;
   end
endmodule // pbio_link_model
`default_nettype wire

// *** sim/pbio_bridge_checker.sv ***
// Assertions on the bridge configuration block ports
`timescale 1ns/1ns
`default_nettype none
module pbio_bridge_checker (
   input wire logic        clk_sys, rst_n, cfg_wr, cfg_rd, cfg_rvalid_r,
   input wire logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata_r,
   input wire logic        ev_poisoned_tlp, ev_err_msg, ev_cpl_ur, ev_cpl_ca,
   input wire logic        io_valid, io_fwd_valid_r, io_fwd_hit_r,
   input wire logic [15:0] io_addr
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire logic rd_sts = cfg_rd && cfg_addr == 8'h1F;
   property p_ro(a, m);
      cfg_rd && cfg_addr == a |=> cfg_rvalid_r && (cfg_rdata_r & m) == 8'h00;
   endproperty
   property p_log(ev, b);
      ev ##1 rd_sts |=> cfg_rvalid_r && cfg_rdata_r[b];
   endproperty
   a_lt_zero: assert property (p_ro(8'h1B, 8'hFF)) else $error("timer");
   a_base_cap: assert property (p_ro(8'h1C, 8'h0F)) else $error("base");
   a_limit_cap: assert property (p_ro(8'h1D, 8'h0F)) else $error("limit");
   a_dpe_log: assert property (p_log(ev_poisoned_tlp, 7)) else $error("dpe");
   a_syserr_log: assert property (p_log(ev_err_msg, 6)) else $error("system error");
   a_rma_log: assert property (p_log(ev_cpl_ur, 5)) else $error("rma");
   a_rta_log: assert property (p_log(ev_cpl_ca, 4)) else $error("rta");
   a_io_answer: assert property (io_valid |=> io_fwd_valid_r) else $error("io");
   a_hit_qual: assert property (io_fwd_hit_r |-> io_fwd_valid_r) else $error("hit alone");
   c_hit: cover property (io_fwd_hit_r);
   c_clr: cover property (cfg_wr && cfg_addr == 8'h1F && cfg_wdata != 8'h00);
   c_flag: cover property (cfg_rvalid_r && cfg_rdata_r[7]);
endmodule // pbio_bridge_checker
bind pbio_bridge pbio_bridge_checker u_pbio_bridge_checker (.*);
`default_nettype wire

// *** sim/tb_pbio_bridge.sv ***
// Bench for the bridge configuration block
`timescale 1ns/1ns
`default_nettype none
module tb_pbio_bridge;
   logic        clk_sys, rst_n, cfg_wr, cfg_rd, io_valid, fire, cfg_rvalid_r, vld, hit;
   logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata_r;
   logic [15:0] io_addr;
   logic [3:0]  ev;
   logic [1:0]  kind;
   int          bad_count, cmp_count;
   pbio_bridge u_pbio_bridge (.clk_sys, .rst_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata,
      .cfg_rdata_r, .cfg_rvalid_r, .ev_poisoned_tlp(ev[3]), .ev_err_msg(ev[2]),
      .ev_cpl_ur(ev[1]), .ev_cpl_ca(ev[0]), .io_valid, .io_addr,
      .io_fwd_valid_r(vld), .io_fwd_hit_r(hit));
   pbio_link_model u_pbio_link_model (.clk_sys, .fire, .kind, .ev_r(ev));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic give_verdict;
      $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge clk_sys);
      cfg_wr <= 1'b0;
   endtask
   // Missing valid turns the data into a value no test expects
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      cfg_rd <= 1'b1;
      cfg_addr <= a;
      @(posedge clk_sys);
      cfg_rd <= 1'b0;
      #1 chk(cfg_rvalid_r === 1'b1 ? cfg_rdata_r : 8'hEE, e);
   endtask
   task automatic io(input logic [15:0] a, input logic h);
      @(posedge clk_sys);
      io_valid <= 1'b1;
      io_addr <= a;
      @(posedge clk_sys);
      io_valid <= 1'b0;
      #1 chk({6'h00, vld, hit}, {7'h01, h});
   endtask
   task automatic pulse(input logic [1:0] k);
      @(posedge clk_sys);
      fire <= 1'b1;
      kind <= k;
      @(posedge clk_sys);
      fire <= 1'b0;
   endtask
   initial begin
      repeat (2000) @(posedge clk_sys);
      bad_count++;
      give_verdict;
   end
   initial begin
      {rst_n, cfg_wr, cfg_rd, io_valid, fire, kind, cfg_addr, cfg_wdata, io_addr} = '0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(8'h1B, 8'h00);
      rd(8'h1C, 8'h00);
      rd(8'h1D, 8'h00);
      rd(8'h1F, 8'h00);
      wr(8'h1B, 8'hFF);
      rd(8'h1B, 8'h00);
      wr(8'h1C, 8'hA5);
      rd(8'h1C, 8'hA0);
      wr(8'h1D, 8'hCF);
      rd(8'h1D, 8'hC0);
      io(16'hA000, 1'b1);
      io(16'h9FFF, 1'b0);
      io(16'hCFFF, 1'b1);
      io(16'hD000, 1'b0);
      for (int k = 0; k < 4; k++) begin
         pulse(k[1:0]);
         rd(8'h1F, 8'h10 << k);
         wr(8'h1F, 8'h00);
         rd(8'h1F, 8'h10 << k);
         wr(8'h1F, 8'h10 << k);
         rd(8'h1F, 8'h00);
      end
      rd(8'h1E, 8'h00);
      // Clear lands on the same edge as the event
      pulse(2'd0);
      cfg_wr <= 1'b1;
      cfg_addr <= 8'h1F;
      cfg_wdata <= 8'h10;
      @(posedge clk_sys);
      cfg_wr <= 1'b0;
      rd(8'h1F, 8'h10);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(8'h1C, 8'h00);
      rd(8'h1F, 8'h00);
      give_verdict;
   end
endmodule // tb_pbio_bridge
`default_nettype wire
